// *** hdl/ptcs_core.sv ***
// machine control bits, illegal-instruction checks, wait timeout and context status summary
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ptcs_regs.svh"
module ptcs_core import ptcs_pkg::*; #(
   parameter bit HAS_S = 1'b1,
   parameter bit HAS_U = 1'b1,
   parameter bit HAS_F = 1'b1,
   parameter bit HAS_V = 1'b1,
   parameter bit KEEP_FS_NO_F = 1'b0,
   parameter bit KEEP_VS_NO_V = 1'b0,
   parameter int N_EXT = 1,
   parameter int WFI_LIMIT_CYC = `PTCS_WFI_LIMIT_NS / `PTCS_CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PTCS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction check port from the pipeline
   input wire logic instr_valid,
   input wire ptcs_kind_t instr_kind,
   input wire logic [2:0] instr_unit,
   input wire ptcs_mode_t instr_mode,
   input wire logic wfi_wake,
   output logic instr_ready,
   output logic rsp_valid,
   output logic rsp_illegal,
   // per-unit reinitialise requests: 0 float, 1 vector, then extensions
   output logic [N_EXT+1:0] unit_init
);
   localparam int NU = N_EXT + `PTCS_STD_UNITS;
   localparam bit HAS_LOWER = HAS_S || HAS_U;
   localparam bit FS_ON = HAS_F || (HAS_S && KEEP_FS_NO_F);
   localparam bit VS_ON = HAS_V || (HAS_S && KEEP_VS_NO_V);
   localparam logic [15:0] WFI_LAST = 16'(WFI_LIMIT_CYC - 1);

   // refuse configurations the logic cannot serve
   if (N_EXT < 0 || N_EXT > `PTCS_MAX_EXT) begin : g_bad_ext
      $error("N_EXT out of range");
   end
   if (WFI_LIMIT_CYC < 0 || WFI_LIMIT_CYC >= (1 << `PTCS_WFI_CNT_W)) begin : g_bad_lim
      $error("WFI_LIMIT_CYC out of range");
   end
   if (HAS_S && !HAS_U) begin : g_bad_modes
      $error("supervisor mode needs user mode");
   end

   ptcs_core_st_t st_r;
   ptcs_core_st_t st_nxt;
   logic [NU-1:0][1:0] unit_st;
   logic [NU-1:0] sw_we;
   logic [NU-1:0][1:0] sw_val;
   logic [NU-1:0] ev_mod;
   logic [NU-1:0] ev_en;
   logic [NU-1:0] ev_dis;
   logic [NU-1:0] ev_unc;
   logic [2:0] rsel;
   logic wr_acc;
   logic setup;
   logic acc;
   logic unit_ok;
   logic unit_off;
   logic ill_now;
   logic wfi_trap_mode;
   logic [1:0] xs;
   logic sd;

   // one-hot register select {ext, ctx, ctrl}; zero means unmapped
   function automatic logic [2:0] reg_sel(input logic [`PTCS_ADDR_W-1:0] a);
      logic [2:0] s;
      s = 3'h0;
      if (a == `PTCS_OFF_CTRL) begin
         s = 3'h1;
      end else if (a == `PTCS_OFF_CTX) begin
         s = 3'h2;
      end else if (a == `PTCS_OFF_EXT) begin
         s = 3'h4;
      end
      return s;
   endfunction

   // largest extension status; zero when there are none
   function automatic logic [1:0] ext_max(input logic [NU-1:0][1:0] v);
      logic [1:0] m;
      m = 2'h0;
      for (int i = `PTCS_STD_UNITS; i < NU; i++) begin
         if (v[i] > m) begin
            m = v[i];
         end
      end
      return m;
   endfunction

   // apb handshakes; registers answer without wait states
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rsel = reg_sel(paddr);
   assign pready = 1'h1;
   assign prdata = st_r.prdata;
   assign pslverr = st_r.pslverr;

   // instruction acceptance; a pending wait blocks the next instruction
   assign instr_ready = st_r.fsm == PTCS_IDLE;
   assign acc = instr_valid && instr_ready;
   assign unit_ok = 32'(instr_unit) < NU;
   assign unit_off = unit_ok ? unit_st[instr_unit] == PTCS_OFF : 1'h1;
   assign wfi_trap_mode = instr_mode != PTCS_M && (st_r.tw || (instr_mode == PTCS_U && HAS_S));

   // illegal decision for everything except the wait, which the state machine times
   always_comb begin
      ill_now = 1'h0;
      case (instr_kind)
         PTCS_K_TBASE, PTCS_K_FENCE, PTCS_K_INVAL: ill_now = instr_mode == PTCS_S && st_r.translation_trap_bit;
         PTCS_K_SUPERVISOR_RETURN_INSTR: ill_now = instr_mode == PTCS_S && st_r.return_trap_bit;
         PTCS_K_READ, PTCS_K_MODIFY, PTCS_K_UNCONFIG: ill_now = unit_off;
         // float and vector have no enable or disable instructions
         PTCS_K_ENABLE, PTCS_K_DISABLE: ill_now = !unit_ok || instr_unit < 3'(`PTCS_STD_UNITS);
         default: ill_now = 1'h0;
      endcase
   end

   // summary fields
   assign xs = ext_max(unit_st);
   assign sd = unit_st[0] == PTCS_DIRTY || unit_st[1] == PTCS_DIRTY || xs == PTCS_DIRTY;

   // one tracker per unit; float and vector written through ctx, extensions through ext
   for (genvar u = 0; u < NU; u++) begin : g_unit
      localparam bit PRES = (u == 0) ? FS_ON : (u == 1) ? VS_ON : 1'b1;
      assign ev_mod[u] = acc && instr_kind == PTCS_K_MODIFY && 32'(instr_unit) == u && !ill_now;
      assign ev_en[u] = acc && instr_kind == PTCS_K_ENABLE && 32'(instr_unit) == u && !ill_now;
      assign ev_dis[u] = acc && instr_kind == PTCS_K_DISABLE && 32'(instr_unit) == u && !ill_now;
      assign ev_unc[u] = acc && instr_kind == PTCS_K_UNCONFIG && 32'(instr_unit) == u && !ill_now;
      if (u == 0) begin : g_fs
         assign sw_we[u] = wr_acc && rsel[1] && pstrb[0];
         assign sw_val[u] = pwdata[`PTCS_CTX_FS_LO +: 2];
      end else if (u == 1) begin : g_vs
         assign sw_we[u] = wr_acc && rsel[1] && pstrb[0];
         assign sw_val[u] = pwdata[`PTCS_CTX_VS_LO +: 2];
      end else begin : g_xs
         assign sw_we[u] = wr_acc && rsel[2] && pstrb[(2 * (u - `PTCS_STD_UNITS)) / 8];
         assign sw_val[u] = pwdata[2 * (u - `PTCS_STD_UNITS) +: 2];
      end
      ptcs_ctx_track #(.PRESENT(PRES)) u_track (
         .pclk(pclk),
         .presetn(presetn),
         .sw_we(sw_we[u]),
         .sw_val(sw_val[u]),
         .ev_mod(ev_mod[u]),
         .ev_enable(ev_en[u]),
         .ev_disable(ev_dis[u]),
         .ev_unconfig(ev_unc[u]),
         .status(unit_st[u]),
         .init_pulse(unit_init[u])
      );
   end

   // next state: control bits, apb read data, instruction answers and the wait timer
   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp_valid = 1'h0;
      st_nxt.rsp_illegal = 1'h0;
      // control bits that cannot exist stay zero whatever is written
      if (wr_acc && rsel[0] && pstrb[0]) begin
         st_nxt.translation_trap_bit = HAS_S && pwdata[`PTCS_CTRL_TVM];
         st_nxt.tw = HAS_LOWER && pwdata[`PTCS_CTRL_TW];
         st_nxt.return_trap_bit = HAS_S && pwdata[`PTCS_CTRL_TSR];
      end
      // read data is captured in the setup cycle so it is stable through the access phase
      if (setup) begin
         st_nxt.prdata = 32'h0;
         st_nxt.pslverr = 1'h0;
         if (rsel[0]) begin
            st_nxt.prdata[`PTCS_CTRL_TVM] = st_r.translation_trap_bit;
            st_nxt.prdata[`PTCS_CTRL_TW] = st_r.tw;
            st_nxt.prdata[`PTCS_CTRL_TSR] = st_r.return_trap_bit;
         end else if (rsel[1]) begin
            st_nxt.prdata[`PTCS_CTX_FS_LO +: 2] = unit_st[0];
            st_nxt.prdata[`PTCS_CTX_VS_LO +: 2] = unit_st[1];
            st_nxt.prdata[`PTCS_CTX_XS_LO +: 2] = xs;
            st_nxt.prdata[`PTCS_CTX_SD] = sd;
         end else if (rsel[2]) begin
            for (int i = `PTCS_STD_UNITS; i < NU; i++) begin
               st_nxt.prdata[2 * (i - `PTCS_STD_UNITS) +: 2] = unit_st[i];
            end
         end else begin
            st_nxt.pslverr = 1'h1;
         end
      end
      case (st_r.fsm)
         PTCS_IDLE: begin
            if (acc && instr_kind == PTCS_K_WFI) begin
               if (wfi_wake) begin
                  st_nxt.rsp_valid = 1'h1;
               end else if (wfi_trap_mode && WFI_LIMIT_CYC == 0) begin
                  st_nxt.rsp_valid = 1'h1;
                  st_nxt.rsp_illegal = 1'h1;
               end else begin
                  st_nxt.fsm = PTCS_WAIT;
                  st_nxt.wfi_timed = wfi_trap_mode;
                  st_nxt.wfi_cnt = 16'h0;
               end
            end else if (acc) begin
               st_nxt.rsp_valid = 1'h1;
               st_nxt.rsp_illegal = ill_now;
            end
         end
         PTCS_WAIT: begin
            // a wake in the last counted cycle still completes the wait
            if (wfi_wake) begin
               st_nxt.rsp_valid = 1'h1;
               st_nxt.fsm = PTCS_IDLE;
            end else if (st_r.wfi_timed && st_r.wfi_cnt == WFI_LAST) begin
               st_nxt.rsp_valid = 1'h1;
               st_nxt.rsp_illegal = 1'h1;
               st_nxt.fsm = PTCS_IDLE;
            end else begin
               st_nxt.wfi_cnt = 16'(st_r.wfi_cnt + 16'h1);
            end
         end
         default: st_nxt.fsm = PTCS_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.translation_trap_bit <= `PTCS_CTRL_RST;
         st_r.tw <= `PTCS_CTRL_RST;
         st_r.return_trap_bit <= `PTCS_CTRL_RST;
         st_r.fsm <= PTCS_IDLE;
         st_r.wfi_timed <= 1'h0;
         st_r.wfi_cnt <= 16'h0;
         st_r.rsp_valid <= 1'h0;
         st_r.rsp_illegal <= 1'h0;
         st_r.prdata <= 32'h0;
         st_r.pslverr <= 1'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rsp_valid = st_r.rsp_valid;
   assign rsp_illegal = st_r.rsp_illegal;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_tvm_trap: assert property (
      acc && instr_kind inside {PTCS_K_TBASE, PTCS_K_FENCE, PTCS_K_INVAL} && instr_mode == PTCS_S
      |=> rsp_valid && rsp_illegal == $past(st_r.translation_trap_bit))
      else $error("translation access answer wrong");
   chk_tvm_const: assert property (
      !HAS_S && wr_acc && rsel[0] && pwdata[`PTCS_CTRL_TVM] |=> !st_r.translation_trap_bit && !st_r.return_trap_bit)
      else $error("trap bit set without supervisor");
   chk_tw_const: assert property (
      !HAS_LOWER |-> !st_r.tw)
      else $error("wait trap bit set without lower modes");
   chk_wfi_timeout: assert property (
      st_r.fsm == PTCS_WAIT && st_r.wfi_timed && !wfi_wake && st_r.wfi_cnt == WFI_LAST
      |=> rsp_valid && rsp_illegal && instr_ready)
      else $error("timed wait did not trap at limit");
   chk_wfi_free: assert property (
      st_r.fsm == PTCS_WAIT && !st_r.wfi_timed |-> ##1 !rsp_illegal)
      else $error("untimed wait trapped");
   chk_wfi_zero: assert property (
      WFI_LIMIT_CYC == 0 && acc && instr_kind == PTCS_K_WFI && wfi_trap_mode && !wfi_wake
      |=> rsp_valid && rsp_illegal)
      else $error("zero limit wait did not trap at once");
   chk_user_wfi: assert property (
      HAS_S && acc && instr_kind == PTCS_K_WFI && instr_mode == PTCS_U && !wfi_wake
      |=> st_r.wfi_timed || rsp_illegal)
      else $error("user wait not timed");
   chk_supervisor_return_instr_trap: assert property (
      acc && instr_kind == PTCS_K_SUPERVISOR_RETURN_INSTR && instr_mode == PTCS_S |=> rsp_valid && rsp_illegal == $past(st_r.return_trap_bit))
      else $error("supervisor return answer wrong");
   chk_off_trap: assert property (
      acc && instr_kind inside {PTCS_K_READ, PTCS_K_MODIFY} && unit_off |=> rsp_valid && rsp_illegal)
      else $error("access to off unit not trapped");
   chk_sd_or: assert property (
      sd == (unit_st[0] == PTCS_DIRTY || unit_st[1] == PTCS_DIRTY || xs == PTCS_DIRTY))
      else $error("dirty bit disagrees with fields");
   chk_xs_max: assert property (
      N_EXT == 0 || xs == unit_st[`PTCS_STD_UNITS] || xs > unit_st[`PTCS_STD_UNITS])
      else $error("summary below an extension status");

   // constant-zero fields for configurations that lack the mode or unit
   chk_tsr_const: assert property (
      !HAS_S |-> !st_r.return_trap_bit)
      else $error("return trap bit set without supervisor");
   chk_fs_absent: assert property (
      !FS_ON |-> unit_st[0] == PTCS_OFF)
      else $error("absent float status not zero");
   chk_vs_absent: assert property (
      !VS_ON |-> unit_st[1] == PTCS_OFF)
      else $error("absent vector status not zero");
   chk_xs_none: assert property (
      N_EXT == 0 |-> xs == PTCS_OFF)
      else $error("summary nonzero without extensions");
   chk_sd_zero: assert property (
      !FS_ON && !VS_ON && N_EXT == 0 |-> !sd)
      else $error("dirty bit set with all fields absent");

   // software view of the status word and the control bits
   chk_ctx_readback: assert property (
      setup && rsel[1] |=> prdata[`PTCS_CTX_SD] == $past(sd) && prdata[`PTCS_CTX_XS_LO +: 2] == $past(xs))
      else $error("status word read back wrong");
   chk_ctrl_write: assert property (
      wr_acc && rsel[0] && pstrb[0]
      |=> st_r.translation_trap_bit == (HAS_S && $past(pwdata[`PTCS_CTRL_TVM])) && st_r.return_trap_bit == (HAS_S && $past(pwdata[`PTCS_CTRL_TSR])))
      else $error("control write stored wrong value");
   chk_fs_write: assert property (
      wr_acc && rsel[1] && pstrb[0] && FS_ON && !ev_mod[0] && !ev_unc[0]
      |=> unit_st[0] == $past(pwdata[`PTCS_CTX_FS_LO +: 2]))
      else $error("float status write not stored");
   // the summary moves only through the extension register or instructions
   chk_xs_no_write: assert property (
      !(wr_acc && rsel[2]) && !acc |=> $stable(xs))
      else $error("summary changed without a cause");
   chk_unmapped_err: assert property (
      setup && rsel == 3'h0 |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");

   // instruction answers
   chk_mod_legal: assert property (
      acc && instr_kind == PTCS_K_MODIFY && !unit_off |=> rsp_valid && !rsp_illegal)
      else $error("modify of live unit refused");
   chk_init_pulse: assert property (
      acc && instr_kind == PTCS_K_ENABLE && !ill_now |=> unit_init != '0)
      else $error("enable gave no reinitialise pulse");
   chk_disable_off: assert property (
      acc && instr_kind == PTCS_K_DISABLE && !ill_now && unit_ok |=> unit_st[$past(instr_unit)] == PTCS_OFF)
      else $error("disable did not turn unit off");
   chk_wait_m_free: assert property (
      acc && instr_kind == PTCS_K_WFI && instr_mode == PTCS_M |-> !wfi_trap_mode)
      else $error("machine mode wait timed");
endmodule
`default_nettype wire

// *** hdl/ptcs_ctx_track.sv ***
// one context status field (float, vector or extension) with its instruction-driven transitions
`timescale 1ns/100ps
`default_nettype none
`include "ptcs_regs.svh"
module ptcs_ctx_track import ptcs_pkg::*; #(
   parameter bit PRESENT = 1'b1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // software write of the field
   input wire logic sw_we,
   input wire logic [1:0] sw_val,
   // instruction events, already checked legal
   input wire logic ev_mod,
   input wire logic ev_enable,
   input wire logic ev_disable,
   input wire logic ev_unconfig,
   // status and unit reinitialise request
   output logic [1:0] status,
   output logic init_pulse
);
   ptcs_trk_st_t st_r;
   ptcs_trk_st_t st_nxt;

   // hardware events beat a software write in the same cycle, so dirtiness is never lost
   always_comb begin
      st_nxt = st_r;
      st_nxt.init = 1'h0;
      if (!PRESENT) begin
         st_nxt.st = PTCS_OFF;
      end else if (ev_disable) begin
         st_nxt.st = PTCS_OFF;
      end else if (ev_enable) begin
         st_nxt.st = PTCS_INIT;
         st_nxt.init = 1'h1;
      end else if (ev_unconfig) begin
         st_nxt.st = PTCS_INIT;
      end else if (ev_mod) begin
         st_nxt.st = PTCS_DIRTY;
      end else if (sw_we) begin
         // every code is legal; no init request, so unit contents survive
         st_nxt.st = ptcs_ctx_t'(sw_val);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.st <= ptcs_ctx_t'(`PTCS_CTX_RST);
         st_r.init <= 1'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign status = st_r.st;
   assign init_pulse = st_r.init;

   chk_enable_init: assert property (@(posedge pclk) disable iff (!presetn)
      PRESENT && ev_enable |=> init_pulse && status == PTCS_INIT)
      else $error("enable did not reinitialise unit");
   chk_mod_dirty: assert property (@(posedge pclk) disable iff (!presetn)
      PRESENT && ev_mod && !ev_enable && !ev_disable && !ev_unconfig |=> status == PTCS_DIRTY)
      else $error("modify did not mark unit dirty");
   chk_absent_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !PRESENT |-> status == PTCS_OFF && !init_pulse)
      else $error("absent unit shows nonzero status");
endmodule
`default_nettype wire

// *** hdl/ptcs_pkg.sv ***
// types shared by the trap and context status block
package ptcs_pkg;
   typedef enum logic [1:0] {PTCS_U = 2'h0, PTCS_S = 2'h1, PTCS_M = 2'h3} ptcs_mode_t;
   typedef enum logic [1:0] {PTCS_OFF = 2'h0, PTCS_INIT = 2'h1, PTCS_CLEAN = 2'h2, PTCS_DIRTY = 2'h3} ptcs_ctx_t;
   typedef enum logic [3:0] {
      PTCS_K_NONE = 4'h0, PTCS_K_TBASE = 4'h1, PTCS_K_FENCE = 4'h2, PTCS_K_INVAL = 4'h3,
      PTCS_K_WFI = 4'h4, PTCS_K_SUPERVISOR_RETURN_INSTR = 4'h5, PTCS_K_READ = 4'h6, PTCS_K_MODIFY = 4'h7,
      PTCS_K_ENABLE = 4'h8, PTCS_K_DISABLE = 4'h9, PTCS_K_UNCONFIG = 4'ha
   } ptcs_kind_t;
   typedef enum logic {PTCS_IDLE = 1'b0, PTCS_WAIT = 1'b1} ptcs_fsm_t;
   typedef struct packed {
      logic translation_trap_bit;
      logic tw;
      logic return_trap_bit;
      ptcs_fsm_t fsm;
      logic wfi_timed;
      logic [15:0] wfi_cnt;
      logic rsp_valid;
      logic rsp_illegal;
      logic [31:0] prdata;
      logic pslverr;
   } ptcs_core_st_t;
   typedef struct packed {
      ptcs_ctx_t st;
      logic init;
   } ptcs_trk_st_t;
endpackage

// *** hdl/ptcs_regs.svh ***
// register map, field positions, reset values and timing for the trap and context status block
`ifndef PTCS_REGS_SVH
`define PTCS_REGS_SVH
`define PTCS_ADDR_W 8
`define PTCS_OFF_CTRL 8'h00
`define PTCS_OFF_CTX 8'h04
`define PTCS_OFF_EXT 8'h08
`define PTCS_CTRL_TVM 0
`define PTCS_CTRL_TW 1
`define PTCS_CTRL_TSR 2
`define PTCS_CTX_FS_LO 0
`define PTCS_CTX_VS_LO 2
`define PTCS_CTX_XS_LO 4
`define PTCS_CTX_SD 31
`define PTCS_CTRL_RST 1'h0
`define PTCS_CTX_RST 2'h0
`define PTCS_MAX_EXT 6
`define PTCS_STD_UNITS 2
`define PTCS_CLK_PERIOD_NS 10
`define PTCS_WFI_LIMIT_NS 640
`define PTCS_WFI_CNT_W 16
`endif

// *** test/ptcs_core_tb.sv ***
// self-checking bench for the trap and context status block
`timescale 1ns/100ps
`default_nettype none
`include "ptcs_regs.svh"
module ptcs_core_tb import ptcs_pkg::*;;
   localparam int NE = 1;
   localparam int LIM = 4;
   typedef struct packed {
      logic [2:0] ctrl;
      ptcs_kind_t kind;
      logic [2:0] unit;
      ptcs_mode_t mode;
      logic ill;
   } ptcs_row_t;
   // clock, reset and apb
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [`PTCS_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr;
   // instruction port
   logic instr_valid = 1'b0;
   ptcs_kind_t instr_kind = PTCS_K_NONE;
   logic [2:0] instr_unit = 3'h0;
   ptcs_mode_t instr_mode = PTCS_M;
   logic wfi_wake = 1'b0;
   logic instr_ready, rsp_valid, rsp_illegal;
   logic [NE+1:0] unit_init, ui_seen;
   int n_fail = 0, compares = 0, cycles = 0;
   logic ill;
   int cyc;
   ptcs_row_t rows [14] = '{
      '{3'h1, PTCS_K_TBASE, 3'h0, PTCS_S, 1'b1}, '{3'h1, PTCS_K_FENCE, 3'h0, PTCS_S, 1'b1},
      '{3'h1, PTCS_K_INVAL, 3'h0, PTCS_S, 1'b1}, '{3'h0, PTCS_K_FENCE, 3'h0, PTCS_S, 1'b0},
      '{3'h1, PTCS_K_FENCE, 3'h0, PTCS_M, 1'b0}, '{3'h4, PTCS_K_SUPERVISOR_RETURN_INSTR, 3'h0, PTCS_S, 1'b1},
      '{3'h0, PTCS_K_SUPERVISOR_RETURN_INSTR, 3'h0, PTCS_S, 1'b0}, '{3'h4, PTCS_K_SUPERVISOR_RETURN_INSTR, 3'h0, PTCS_M, 1'b0},
      '{3'h0, PTCS_K_WFI, 3'h0, PTCS_S, 1'b0}, '{3'h2, PTCS_K_WFI, 3'h0, PTCS_S, 1'b0},
      '{3'h0, PTCS_K_READ, 3'h0, PTCS_U, 1'b0}, '{3'h0, PTCS_K_ENABLE, 3'h0, PTCS_U, 1'b1},
      '{3'h0, PTCS_K_READ, 3'h5, PTCS_U, 1'b1}, '{3'h0, PTCS_K_READ, 3'h2, PTCS_U, 1'b1}
   };

   ptcs_core #(.N_EXT(NE), .WFI_LIMIT_CYC(LIM)) i_ptcs_core (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instr_valid(instr_valid), .instr_kind(instr_kind),
      .instr_unit(instr_unit), .instr_mode(instr_mode), .wfi_wake(wfi_wake),
      .instr_ready(instr_ready), .rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal),
      .unit_init(unit_init)
   );

   // 100 MHz clock
   always #5 pclk = ~pclk;

   task automatic wrap_up();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask

   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, a > `PTCS_OFF_EXT});
   endtask

   // present one instruction, wait for its answer; cyc counts edges after the taking edge
   task automatic instr(input ptcs_kind_t k, input logic [2:0] u, input ptcs_mode_t m,
                        input logic wk, output logic il, output int c);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_kind <= k;
      instr_unit <= u;
      instr_mode <= m;
      wfi_wake <= wk;
      @(posedge pclk);
      instr_valid <= 1'b0;
      c = 0;
      ui_seen = '0;
      do begin
         @(posedge pclk);
         c++;
         ui_seen |= unit_init;
      end while (rsp_valid !== 1'b1 && c < 200);
      il = rsp_illegal;
      // a missing answer is a failure, not a silent pass
      if (rsp_valid !== 1'b1) begin
         $display("[ERR] t=%0t got %h exp %h", $time, c, 1);
         n_fail++;
      end
      wfi_wake <= 1'b0;
   endtask

   task automatic ichk(input ptcs_kind_t k, input logic [2:0] u, input logic exp);
      instr(k, u, PTCS_U, 1'b0, ill, cyc);
      chk({31'h0, ill}, {31'h0, exp});
      chk(cyc, 1);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   initial begin
      do_reset();
      rdchk(`PTCS_OFF_CTX, 32'h0);
      // floating and vector units clean for the table
      wr(`PTCS_OFF_CTX, 32'ha);
      foreach (rows[i]) begin
         wr(`PTCS_OFF_CTRL, {29'h0, rows[i].ctrl});
         instr(rows[i].kind, rows[i].unit, rows[i].mode, 1'b1, ill, cyc);
         chk({31'h0, ill}, {31'h0, rows[i].ill});
         chk(cyc, 1);
      end
      wr(`PTCS_OFF_CTRL, 32'h7);
      rdchk(`PTCS_OFF_CTRL, 32'h7);
      // summary and dirty bits ignore writes, float field stores the code
      wr(`PTCS_OFF_CTX, 32'h8000_0031);
      rdchk(`PTCS_OFF_CTX, 32'h1);
      ichk(PTCS_K_MODIFY, 3'h0, 1'b0);
      rdchk(`PTCS_OFF_CTX, 32'h8000_0003);
      ichk(PTCS_K_MODIFY, 3'h1, 1'b1);
      rdchk(`PTCS_OFF_CTX, 32'h8000_0003);
      wr(`PTCS_OFF_CTX, 32'h2);
      rdchk(`PTCS_OFF_CTX, 32'h2);
      // extension unit: enable, modify, unconfigure, software write, disable
      ichk(PTCS_K_ENABLE, 3'h2, 1'b0);
      chk({29'h0, ui_seen}, 32'h4);
      rdchk(`PTCS_OFF_EXT, 32'h1);
      rdchk(`PTCS_OFF_CTX, 32'h12);
      ichk(PTCS_K_MODIFY, 3'h2, 1'b0);
      rdchk(`PTCS_OFF_CTX, 32'h8000_0032);
      ichk(PTCS_K_UNCONFIG, 3'h2, 1'b0);
      rdchk(`PTCS_OFF_CTX, 32'h12);
      wr(`PTCS_OFF_EXT, 32'h2);
      rdchk(`PTCS_OFF_CTX, 32'h22);
      ichk(PTCS_K_DISABLE, 3'h2, 1'b0);
      rdchk(`PTCS_OFF_EXT, 32'h0);
      ichk(PTCS_K_DISABLE, 3'h2, 1'b0);
      ichk(PTCS_K_UNCONFIG, 3'h2, 1'b1);
      rdchk(`PTCS_OFF_CTX, 32'h2);
      // unmapped address answers with an error and zero data
      rdchk(8'h0c, 32'h0);
      // timed waits without wake trap after exactly the limit
      wr(`PTCS_OFF_CTRL, 32'h2);
      instr(PTCS_K_WFI, 3'h0, PTCS_S, 1'b0, ill, cyc);
      chk({31'h0, ill}, 32'h1);
      chk(cyc, LIM + 1);
      wr(`PTCS_OFF_CTRL, 32'h0);
      instr(PTCS_K_WFI, 3'h0, PTCS_U, 1'b0, ill, cyc);
      chk({31'h0, ill}, 32'h1);
      chk(cyc, LIM + 1);
      // machine mode wait holds off requests until woken, then completes legally
      fork
         instr(PTCS_K_WFI, 3'h0, PTCS_M, 1'b0, ill, cyc);
         begin
            repeat (8) @(posedge pclk);
            chk({31'h0, instr_ready}, 32'h0);
            wfi_wake <= 1'b1;
         end
      join
      chk({31'h0, ill}, 32'h0);
      // second reset in mid-run clears control bits and statuses
      wr(`PTCS_OFF_CTRL, 32'h7);
      wr(`PTCS_OFF_CTX, 32'h3);
      do_reset();
      rdchk(`PTCS_OFF_CTRL, 32'h0);
      rdchk(`PTCS_OFF_CTX, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
